/* File: hdl/frsp_ctrl.sv */
// Contract
// - store-program from application section never starts programming
// - programming starts only when the instruction is fetched from boot section
// - boot-section store-program may target any flash page, boot included
// - boot-size fuses set the application/boot boundary
// - fixed concurrent-read and halting sections split the flash
// - lock bits 0 protect application, lock bits 1 protect boot
// - halting behaviour chosen by target page address, not fetch address
// - concurrent-read-section programming keeps CPU running from halting section
// - halting-section programming stalls the CPU for the whole operation
// - boot section lies entirely inside the halting section
// - busy flag reads one while concurrent-read section is blocked
// - target address is latched when programming starts
//
// Chosen here: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
module frsp_ctrl #(
  parameter int ADDR_W    = 15,                       // flash word address width
  parameter int PAGE_LSB  = 6,                        // words per page exponent
  parameter int HALT_BASE = 15'h7000,                 // first halting-section word
  parameter int PROG_CYC  = frsp_pkg::PROG_CYCLES     // erase/write duration
) (
  input  wire logic              clk,                 // system clock
  input  wire logic              nrst,                // async reset, low
  input  wire logic [7:0]        wb_adr_i,            // wishbone address
  input  wire logic [31:0]       wb_dat_i,            // wishbone write data
  output logic      [31:0]       wb_dat_o,            // wishbone read data
  input  wire logic              wb_we_i,             // write enable
  input  wire logic [3:0]        wb_sel_i,            // byte selects
  input  wire logic              wb_cyc_i,            // cycle
  input  wire logic              wb_stb_i,            // strobe
  output logic                   wb_ack_o,            // acknowledge
  output logic                   wb_err_o,            // unmapped address
  input  wire logic              spmExec,             // store-program instr pulse
  input  wire logic [ADDR_W-1:0] fetchAddr,           // address of that instr
  input  wire logic [15:0]       spmData,             // word for buffer fill
  output logic                   cpuHalt,             // stall the CPU
  output logic                   crsBlocked,          // concurrent-read section unreadable
  output logic                   flashErase,          // page erase pulse
  output logic                   flashWrite,          // page write pulse
  output logic                   bufWrite,            // buffer fill pulse
  output logic [ADDR_W-1:0]      flashAddr,           // latched target address
  output logic [15:0]            bufData,             // buffer fill data
  output logic                   spmDenied            // store-program refused pulse
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    frsp_pkg::frsp_state_t st;
    logic [6:0]            cmd;
    logic [2:0]            arm;
    logic [ADDR_W-1:0]     zptr;
    logic [1:0]            boot_size_fuses;
    logic [3:0]            lock;
    logic                  busy;
    logic                  halting;
    logic                  isErase;
    logic [31:0]           cnt;
    logic [ADDR_W-1:0]     tgt;
    logic [15:0]           data;
    logic                  erase;
    logic                  write;
    logic                  fill;
    logic                  denied;
    logic                  ack;
    logic                  err;
    logic [31:0]           rdat;
  } frsp_regs_t;

  frsp_regs_t r_r;
  frsp_regs_t r_nxt;

  // boot section start as a word address from the size fuses
  function automatic logic [ADDR_W-1:0] bootStart(input logic [1:0] sz);
    bootStart = ADDR_W'((1 << ADDR_W) - (ADDR_W'(512) << (2'h3 - sz)));
  endfunction

  function automatic logic inHalt(input logic [ADDR_W-1:0] a);
    inHalt = (a >= ADDR_W'(HALT_BASE));
  endfunction

  wire logic              inBoot   = fetchAddr >= bootStart(r_r.boot_size_fuses);
  wire logic              bootTgt  = r_r.zptr >= bootStart(r_r.boot_size_fuses);
  wire logic              locked   = bootTgt ? r_r.lock[2] : r_r.lock[0];
  wire logic              wbReq    = wb_cyc_i && wb_stb_i && !r_r.ack && !r_r.err;
  wire logic              wbWr     = wbReq && wb_we_i && wb_sel_i[0];

  always_comb begin
    r_nxt        = r_r;
    r_nxt.erase  = 1'b0;
    r_nxt.write  = 1'b0;
    r_nxt.fill   = 1'b0;
    r_nxt.denied = 1'b0;
    r_nxt.ack    = 1'b0;
    r_nxt.err    = 1'b0;
    // ----------------------------------------------------------------
    // command arming window
    // ----------------------------------------------------------------
    if (r_r.arm != 3'h0) begin
      r_nxt.arm = r_r.arm - 3'h1;
    end
    if (r_r.arm == 3'h1) begin
      r_nxt.cmd = 7'h00;
    end
    // ----------------------------------------------------------------
    // wishbone slave
    // ----------------------------------------------------------------
    if (wbReq) begin
      r_nxt.ack = 1'b1;
      unique case (wb_adr_i)
        frsp_pkg::CTRL_ADDR: begin
          if (wbWr && r_r.st == frsp_pkg::ST_IDLE) begin
            r_nxt.cmd = wb_dat_i[6:0];
            r_nxt.arm = 3'(frsp_pkg::ARM_CYCLES);
          end
        end
        frsp_pkg::ZPTR_ADDR: begin
          if (wbWr) begin
            r_nxt.zptr = wb_dat_i[ADDR_W-1:0];
          end
        end
        frsp_pkg::STATUS_ADDR: begin
        end
        frsp_pkg::FUSE_ADDR: begin
          if (wbWr) begin
            r_nxt.boot_size_fuses = wb_dat_i[1:0];
          end
        end
        default: begin
          r_nxt.ack = 1'b0;
          r_nxt.err = 1'b1;
        end
      endcase
      r_nxt.rdat = 32'h0;
      if (wb_adr_i == frsp_pkg::CTRL_ADDR) begin
        r_nxt.rdat = {24'h0, 1'b0, r_r.busy, r_r.cmd[5:0]};
      end
      if (wb_adr_i == frsp_pkg::ZPTR_ADDR) begin
        r_nxt.rdat = 32'(r_r.zptr);
      end
      if (wb_adr_i == frsp_pkg::STATUS_ADDR) begin
        r_nxt.rdat = {24'h0, r_r.st, r_r.halting, r_r.busy, r_r.lock[2], r_r.lock[0]};
      end
      if (wb_adr_i == frsp_pkg::FUSE_ADDR) begin
        r_nxt.rdat = {30'h0, r_r.boot_size_fuses};
      end
    end
    // ----------------------------------------------------------------
    // store-program sequencing
    // ----------------------------------------------------------------
    unique case (r_r.st)
      frsp_pkg::ST_IDLE: begin
        if (spmExec && r_r.arm != 3'h0) begin
          r_nxt.arm = 3'h0;
          r_nxt.cmd = 7'h00;
          if (!inBoot) begin
            r_nxt.denied = 1'b1;
          end else if (r_r.cmd == frsp_pkg::CMD_FILL) begin
            r_nxt.fill = 1'b1;
            r_nxt.tgt  = r_r.zptr;
            r_nxt.data = spmData;
            r_nxt.st   = frsp_pkg::ST_FILL;
          end else if (r_r.cmd == frsp_pkg::CMD_BUSYCLR) begin
            r_nxt.busy = 1'b0;
          end else if (r_r.cmd == frsp_pkg::CMD_LOCK) begin
            r_nxt.lock = r_r.lock & ~r_r.zptr[3:0];
          end else if ((r_r.cmd == frsp_pkg::CMD_ERASE || r_r.cmd == frsp_pkg::CMD_WRITE)
                       && !locked) begin
            r_nxt.tgt     = {r_r.zptr[ADDR_W-1:PAGE_LSB], PAGE_LSB'(0)};
            r_nxt.isErase = (r_r.cmd == frsp_pkg::CMD_ERASE);
            r_nxt.halting = inHalt(r_r.zptr);
            r_nxt.busy    = r_r.busy | !inHalt(r_r.zptr);
            r_nxt.erase   = (r_r.cmd == frsp_pkg::CMD_ERASE);
            r_nxt.write   = (r_r.cmd == frsp_pkg::CMD_WRITE);
            r_nxt.cnt     = 32'(PROG_CYC);
            r_nxt.st      = frsp_pkg::ST_PROG;
          end else begin
            r_nxt.denied = 1'b1;
          end
        end
      end
      frsp_pkg::ST_FILL: begin
        r_nxt.st = frsp_pkg::ST_IDLE;
      end
      frsp_pkg::ST_PROG: begin
        r_nxt.cnt = r_r.cnt - 32'h1;
        if (r_r.cnt == 32'h1) begin
          r_nxt.st = frsp_pkg::ST_DONE;
        end
      end
      frsp_pkg::ST_DONE: begin
        r_nxt.halting = 1'b0;
        r_nxt.st      = frsp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_r        <= '0;
      r_r.st     <= frsp_pkg::ST_IDLE;
      r_r.boot_size_fuses <= frsp_pkg::BOOT_SIZE_FUSES_RST;
      r_r.lock   <= frsp_pkg::LOCK_RST;
    end else begin
      r_r <= r_nxt;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign wb_dat_o   = r_r.rdat;
  assign wb_ack_o   = r_r.ack;
  assign wb_err_o   = r_r.err;
  assign cpuHalt    = r_r.halting;
  assign crsBlocked = r_r.busy;
  assign flashErase = r_r.erase;
  assign flashWrite = r_r.write;
  assign bufWrite   = r_r.fill;
  assign flashAddr  = r_r.tgt;
  assign bufData    = r_r.data;
  assign spmDenied  = r_r.denied;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_progStart;
    r_r.st == frsp_pkg::ST_IDLE && spmExec && r_r.arm != 3'h0 && inBoot && !locked
      && (r_r.cmd == frsp_pkg::CMD_ERASE || r_r.cmd == frsp_pkg::CMD_WRITE);
  endsequence

  a_app_spm_refused: assert property (@(posedge clk) disable iff (!nrst)
    (spmExec && !inBoot && r_r.arm != 3'h0 && r_r.st == frsp_pkg::ST_IDLE)
      |=> spmDenied && !flashErase && !flashWrite)
    else $error("store-program from application not refused");

  a_boot_spm_starts: assert property (@(posedge clk) disable iff (!nrst)
    s_progStart |=> (flashErase || flashWrite))
    else $error("boot store-program did not start");

  a_addr_latched: assert property (@(posedge clk) disable iff (!nrst)
    (r_r.st == frsp_pkg::ST_PROG && $past(r_r.st) == frsp_pkg::ST_PROG)
      |-> $stable(flashAddr))
    else $error("target address changed mid operation");

  a_halt_by_target: assert property (@(posedge clk) disable iff (!nrst)
    s_progStart |=> cpuHalt == inHalt($past(r_r.zptr)))
    else $error("halt not chosen by target");

  a_halt_throughout: assert property (@(posedge clk) disable iff (!nrst)
    (r_r.st == frsp_pkg::ST_PROG && r_r.halting) |-> cpuHalt)
    else $error("cpu not stalled during halting op");

  a_busy_sets: assert property (@(posedge clk) disable iff (!nrst)
    (s_progStart and !inHalt(r_r.zptr)) |=> crsBlocked)
    else $error("busy flag not set");

  a_busy_reads_one: assert property (@(posedge clk) disable iff (!nrst)
    (wbReq && !wb_we_i && wb_adr_i == frsp_pkg::CTRL_ADDR && r_r.busy)
      |=> wb_dat_o[frsp_pkg::BUSY_BIT])
    else $error("busy flag reads zero");

  a_halt_release: assert property (@(posedge clk) disable iff (!nrst)
    (r_r.st == frsp_pkg::ST_DONE) |=> !cpuHalt)
    else $error("cpu not released");

  a_lock_protects: assert property (@(posedge clk) disable iff (!nrst)
    (spmExec && r_r.arm != 3'h0 && locked && r_r.st == frsp_pkg::ST_IDLE
      && (r_r.cmd == frsp_pkg::CMD_ERASE || r_r.cmd == frsp_pkg::CMD_WRITE))
      |=> !flashErase && !flashWrite)
    else $error("locked section programmed");

  // ----------------------------------------------------------------
  // bus and pulse checks
  // ----------------------------------------------------------------
  sequence s_writeStart;
    s_progStart ##0 r_r.cmd == frsp_pkg::CMD_WRITE;
  endsequence

  sequence s_fillStart;
    r_r.st == frsp_pkg::ST_IDLE && spmExec && r_r.arm != 3'h0 && inBoot
      && r_r.cmd == frsp_pkg::CMD_FILL;
  endsequence

  a_ack_one_cycle: assert property (@(posedge clk) disable iff (!nrst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  a_req_answered: assert property (@(posedge clk) disable iff (!nrst)
    wbReq |=> (wb_ack_o || wb_err_o))
    else $error("bus request not answered");

  a_erase_single: assert property (@(posedge clk) disable iff (!nrst)
    flashErase |=> !flashErase)
    else $error("erase pulse longer than one cycle");

  a_write_kind: assert property (@(posedge clk) disable iff (!nrst)
    s_writeStart |=> flashWrite && !flashErase)
    else $error("page write not issued as write");

  a_fill_starts: assert property (@(posedge clk) disable iff (!nrst)
    s_fillStart |=> bufWrite && bufData == $past(spmData))
    else $error("buffer fill not issued");

  a_any_page: assert property (@(posedge clk) disable iff (!nrst)
    s_progStart |=> flashAddr[ADDR_W-1:PAGE_LSB] == $past(r_r.zptr[ADDR_W-1:PAGE_LSB]))
    else $error("target page not taken");

  a_busy_clear_only: assert property (@(posedge clk) disable iff (!nrst)
    $fell(crsBlocked) |-> $past(r_r.cmd) == frsp_pkg::CMD_BUSYCLR)
    else $error("busy flag dropped without clear");

  a_boot_in_halt: assert property (@(posedge clk) disable iff (!nrst)
    inHalt(bootStart(r_r.boot_size_fuses)))
    else $error("boot section outside halting section");

  a_crs_runs: assert property (@(posedge clk) disable iff (!nrst)
    (s_progStart and !inHalt(r_r.zptr)) |=> !cpuHalt)
    else $error("cpu stalled during concurrent op");

  a_denied_pulse: assert property (@(posedge clk) disable iff (!nrst)
    spmDenied |=> !spmDenied)
    else $error("refusal pulse longer than one cycle");

  a_unarmed_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (spmExec && r_r.arm == 3'h0) |=> !flashErase && !flashWrite && !bufWrite)
    else $error("unarmed store-program started an op");

  a_halt_in_prog: assert property (@(posedge clk) disable iff (!nrst)
    $rose(cpuHalt) |-> r_r.st == frsp_pkg::ST_PROG)
    else $error("cpu stalled outside an operation");

endmodule

/* File: hdl/frsp_pkg.sv */
package frsp_pkg;

  // ----------------------------------------------------------------
  // register map (word aligned byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR   = 8'h00;
  localparam logic [7:0] ZPTR_ADDR   = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam logic [7:0] FUSE_ADDR   = 8'h0C;

  // ----------------------------------------------------------------
  // control register fields
  // ----------------------------------------------------------------
  localparam int         CMD_W         = 7;
  localparam logic [6:0] CMD_FILL      = 7'h01;
  localparam logic [6:0] CMD_ERASE     = 7'h03;
  localparam logic [6:0] CMD_WRITE     = 7'h05;
  localparam logic [6:0] CMD_LOCK      = 7'h09;
  localparam logic [6:0] CMD_BUSYCLR   = 7'h11;
  localparam int         BUSY_BIT      = 6;
  localparam logic [7:0] CTRL_RST      = 8'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         ARM_CYCLES    = 4;
  localparam int         CLK_MHZ       = 100;
  localparam int         PROG_US       = 4000;
  localparam int         PROG_CYCLES   = PROG_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BOOT_SIZE_FUSES_RST    = 2'h0;
  localparam logic [3:0] LOCK_RST      = 4'hF;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FILL  = 4'b0010,
    ST_PROG  = 4'b0100,
    ST_DONE  = 4'b1000
  } frsp_state_t;

endpackage

/* File: test/frsp_cpu_model.sv */
`timescale 1ns/100ps
module frsp_cpu_model (
  input  wire logic        clk,       // system clock
  input  wire logic        cpuHalt,   // stall request
  output logic             spmExec,   // store-program pulse
  output logic [14:0]      fetchAddr, // location of that instr
  output logic [15:0]      spmData    // fill word
);
  // ----------------------------------------------------------------
  // boot loader core: fetches only from halting section while busy
  // ----------------------------------------------------------------
  initial begin
    spmExec   = 1'b0;
    fetchAddr = 15'h0000;
    spmData   = 16'h0000;
  end

  // one store-program instr, then stall while halted; returns stall length
  task automatic store_program_instr(input logic [14:0] f, input logic [15:0] d, output int n);
    @(posedge clk);
    spmExec   <= 1'b1;
    fetchAddr <= f;
    spmData   <= d;
    @(posedge clk);
    spmExec   <= 1'b0;
    fetchAddr <= ~f;  // released lines do not keep the last value
    spmData   <= ~d;
    n = 0;
    @(posedge clk);
    while (cpuHalt === 1'b1 && n < 2000) begin
      n++;
      @(posedge clk);
    end
  endtask
endmodule

/* File: test/flash_rww_self_program_control_test.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module flash_rww_self_program_control_test;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, rd;
  logic        we = 1'b0, cyc = 1'b0, stb = 1'b0, ack, err, lastErr;
  logic        spmExec, cpuHalt, crsBlocked, fErase, fWrite, bWrite, denied;
  logic [14:0] fetchAddr, flashAddr;
  logic [15:0] spmData, bufData;
  int          mismatches = 0, num_checks = 0, nOps = 0, nDen = 0, nWr = 0, h, k;

  always #5 clk = ~clk;

  frsp_ctrl #(.PROG_CYC(20)) dut_u (
    .clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_we_i(we), .wb_sel_i(4'hF), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(ack),
    .wb_err_o(err), .spmExec(spmExec), .fetchAddr(fetchAddr), .spmData(spmData),
    .cpuHalt(cpuHalt), .crsBlocked(crsBlocked), .flashErase(fErase),
    .flashWrite(fWrite), .bufWrite(bWrite), .flashAddr(flashAddr), .bufData(bufData),
    .spmDenied(denied));

  frsp_cpu_model cpu_u (.clk(clk), .cpuHalt(cpuHalt), .spmExec(spmExec),
    .fetchAddr(fetchAddr), .spmData(spmData));

  // ----------------------------------------------------------------
  // pulse monitor
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (fErase || fWrite || bWrite) nOps++;
    if (denied) nDen++;
    if (fWrite) nWr++;
  end

  // ----------------------------------------------------------------
  // bus and command tasks
  // ----------------------------------------------------------------
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk);
      t++;
    end while (ack !== 1'b1 && err !== 1'b1 && t < 50);
    rd = rdat;
    lastErr = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
    rd = rdat;
  endtask

  task automatic op(input logic [6:0] c, input logic [14:0] z, input logic [14:0] f,
                    input logic [15:0] d);
    wb(1'b1, frsp_pkg::ZPTR_ADDR, {17'h0, z});
    wb(1'b1, frsp_pkg::CTRL_ADDR, {25'h0, c});
    cpu_u.store_program_instr(f, d, h);
    repeat (2) @(posedge clk);
  endtask

  task automatic idle_clear();
    k = 0;
    do begin
      wb(1'b0, frsp_pkg::STATUS_ADDR, 32'h0);
      k++;
    end while (rd[7:4] !== 4'h1 && k < 100);
    `CHK("crs held", 1'b1, crsBlocked)
    op(frsp_pkg::CMD_BUSYCLR, 15'h0000, 15'h7100, 16'h0000);
    `CHK("crs cleared", 1'b0, crsBlocked)
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    #200000;
    mismatches++;
    results();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, frsp_pkg::STATUS_ADDR, 32'h0);
    `CHK("status rst", 8'h13, rd[7:0])
    op(frsp_pkg::CMD_ERASE, 15'h0140, 15'h7100, 16'h0);
    `CHK("locked deny", 1, nDen)
    op(frsp_pkg::CMD_LOCK, 15'h0005, 15'h7100, 16'h0);
    wb(1'b0, frsp_pkg::STATUS_ADDR, 32'h0);
    `CHK("unlocked", 8'h10, rd[7:0])
    op(frsp_pkg::CMD_ERASE, 15'h0140, 15'h0100, 16'h0);
    `CHK("app deny", 2, nDen)
    `CHK("app no op", 0, nOps)
    op(frsp_pkg::CMD_ERASE, 15'h0140, 15'h7100, 16'h0);
    `CHK("rww ops", 1, nOps)
    `CHK("rww no halt", 0, h)
    `CHK("rww busy", 1'b1, crsBlocked)
    wb(1'b1, frsp_pkg::ZPTR_ADDR, 32'h0080);
    `CHK("addr latch", 15'h0140, flashAddr)
    wb(1'b0, frsp_pkg::CTRL_ADDR, 32'h0);
    `CHK("ctrl busy", 1'b1, rd[frsp_pkg::BUSY_BIT])
    wb(1'b0, frsp_pkg::STATUS_ADDR, 32'h0);
    `CHK("status prog", 8'h44, rd[7:0])
    idle_clear();
    op(frsp_pkg::CMD_ERASE, 15'h6FC0, 15'h7000, 16'h0);
    `CHK("below halt", 0, h)
    idle_clear();
    op(frsp_pkg::CMD_WRITE, 15'h7040, 15'h7000, 16'h0);
    `CHK("halt len", 21, h)
    `CHK("boot target", 15'h7040, flashAddr)
    `CHK("no crs", 1'b0, crsBlocked)
    `CHK("page writes", 1, nWr)
    op(frsp_pkg::CMD_FILL, 15'h0003, 15'h7100, 16'hBEEF);
    `CHK("fill data", 16'hBEEF, bufData)
    `CHK("ops", 4, nOps)
    wb(1'b1, frsp_pkg::CTRL_ADDR, 32'h03);
    repeat (6) @(posedge clk);
    cpu_u.store_program_instr(15'h7100, 16'h0, h);
    repeat (2) @(posedge clk);
    `CHK("arm expired", 4, nOps)
    wb(1'b1, frsp_pkg::FUSE_ADDR, 32'h3);
    op(frsp_pkg::CMD_ERASE, 15'h0140, 15'h7000, 16'h0);
    `CHK("small boot", 3, nDen)
    wb(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 1'b1, lastErr)
    results();
  end
endmodule
